//--- core/ldsc_top.v
// register bank and two-wire slave port of the led driver control block
// assumes all pins sampled synchronously to ref_clk (25 MHz); open-drain
// pins resolved outside from the output enables
// How it works
// - pin starts as active-high hardware enable
// - low enable resets registers, sinks, switch off
// - function bit 0 leaves hardware-enable mode
// - pattern mode repeats 32 bits, frequency, duty
// - four pattern bytes at 0x90 to 0x93
// - pattern one pulls low, zero releases
// - field 000 io, codes 001 to 110 pattern duty
// - field 111 latches pattern bytes into shifter
// - bits 7:6 pick pattern frequency
// - io mode: bit1 direction, bit2 data
// - input mode loads pin level into bit2
// - aux register: direction, data, ones above
// - aux pin follows data or reflects input
// - shut down at 140, resume below 120
// - register byte then data byte stored
// - bytes eight bits, msb first, change low
// - device acknowledges its own address and each byte written after it
// - registers reset to their power-on values
// - enable bits switch sinks or high impedance
// - unison bit drives both from primary
`timescale 1ns/1ps
`default_nettype none
`include "ldsc_regs.vh"

module ldsc_top #(
  parameter SLAVE_ADDR = `LDSC_SLAVE_ADDR,
  parameter SLOT_BASE  = `LDSC_SLOT_CYCLES
) (
  input  wire       ref_clk,
  input  wire       rst_b,
  input  wire       scl,
  input  wire       sdaIn,
  output wire       sdaOut,
  output wire       sdaOe,
  input  wire       mfpIn,
  output wire       mfpOut,
  output reg        mfpOe,
  input  wire       auxIn,
  output wire       auxOut,
  output reg        auxOe,
  input  wire [7:0] dieTemp,
  output reg        primarySinkOn,
  output reg        secondarySinkOn,
  output reg        switchOn,
  output reg  [6:0] primaryCurrent,
  output reg  [6:0] secondaryCurrent,
  output reg  [1:0] rampSelect,
  output reg        oledMode
);

  // slave states
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_ADDR = 5'h02;
  localparam [4:0] S_REG  = 5'h04;
  localparam [4:0] S_DATA = 5'h08;
  localparam [4:0] S_READ = 5'h10;

  reg  [7:0] generalCtl;
  reg  [7:0] pinFunc;
  reg  [7:0] auxCtl;
  reg  [7:0] patByte0;
  reg  [7:0] patByte1;
  reg  [7:0] patByte2;
  reg  [7:0] patByte3;
  reg  [7:0] primaryLevel;
  reg  [7:0] secondaryLevel;

  reg  [4:0] state;
  reg  [3:0] bitCnt;
  reg  [7:0] shiftIn;
  reg  [7:0] readBuf;
  reg  [7:0] regAddr;
  reg        ackPhase;
  reg        masterAck;
  reg        sdaDrive;
  reg        sclPrev;
  reg        sdaPrev;
  reg        wrEn;
  reg  [7:0] wrData;
  reg  [7:0] readData;
  reg        thermalOff;

  wire       sclRise;
  wire       sclFall;
  wire       startSeen;
  wire       stopSeen;
  wire       hwenMode;
  wire       hwShutdown;
  wire [2:0] dutyField;
  wire       patternMode;
  wire       ioMode;
  wire       latchPattern;
  wire       patPullLow;
  wire       deviceOn;

  // bus events from the sampled clock and data lines
  assign sclRise   = scl & ~sclPrev;
  assign sclFall   = ~scl & sclPrev;
  assign startSeen = scl & sclPrev & sdaPrev & ~sdaIn;
  assign stopSeen  = scl & sclPrev & ~sdaPrev & sdaIn;

  // pin function decode; our own pull on the pin never counts as a shutdown
  assign hwenMode     = ~pinFunc[`LDSC_PF_HARDWARE_ENABLE_MODE_OFF];
  assign hwShutdown   = hwenMode & ~mfpIn & ~mfpOe;
  assign dutyField    = pinFunc[`LDSC_PF_DUTY_HI:`LDSC_PF_DUTY_LO];
  assign patternMode  = ~hwenMode & (dutyField != `LDSC_DUTY_IO) &
                        (dutyField != `LDSC_DUTY_LATCH);
  assign ioMode       = ~hwenMode & (dutyField == `LDSC_DUTY_IO);
  assign latchPattern = wrEn & (regAddr == `LDSC_ADDR_PIN_FUNC) &
                        (wrData[`LDSC_PF_DUTY_HI:`LDSC_PF_DUTY_LO] == `LDSC_DUTY_LATCH);
  assign deviceOn     = ~hwShutdown & ~thermalOff;

  // open-drain pins only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOe  = sdaDrive;
  assign mfpOut = 1'b0;
  assign auxOut = 1'b0;

  // pattern generator for the multi-function pin
  ldsc_pattern #(
    .PAT_BITS  (32),
    .SLOT_BASE (SLOT_BASE)
  ) u_pattern (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .clear     (hwShutdown),
    .latch     (latchPattern),
    .patternIn ({patByte3, patByte2, patByte1, patByte0}),
    .freqSel   (pinFunc[`LDSC_PF_FREQ_HI:`LDSC_PF_FREQ_LO]),
    .dutySel   (dutyField),
    .enable    (patternMode),
    .pullLow   (patPullLow)
  );

  // register read mux, fixed ones in the unused general and aux bits
  always @* begin
    case (regAddr)
      `LDSC_ADDR_GENERAL:   readData = generalCtl | `LDSC_GC_FIXED_ONES;
      `LDSC_ADDR_PIN_FUNC:  readData = pinFunc;
      `LDSC_ADDR_AUX_IO:    readData = auxCtl | `LDSC_AUX_FIXED_ONES;
      `LDSC_ADDR_PATTERN0:  readData = patByte0;
      `LDSC_ADDR_PATTERN1:  readData = patByte1;
      `LDSC_ADDR_PATTERN2:  readData = patByte2;
      `LDSC_ADDR_PATTERN3:  readData = patByte3;
      `LDSC_ADDR_PRIMARY:   readData = primaryLevel;
      `LDSC_ADDR_SECONDARY: readData = secondaryLevel;
      default:              readData = 8'h00;
    endcase
  end

  // line history for edge and condition detection
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= scl;
      sdaPrev <= sdaIn;
    end
  end

  // two-wire slave: address, register byte, data bytes, reads
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= S_IDLE;
      bitCnt    <= 4'h0;
      shiftIn   <= 8'h00;
      readBuf   <= 8'h00;
      regAddr   <= 8'h00;
      ackPhase  <= 1'b0;
      masterAck <= 1'b0;
      sdaDrive  <= 1'b0;
      wrEn      <= 1'b0;
      wrData    <= 8'h00;
    end else if (hwShutdown) begin
      state     <= S_IDLE;
      bitCnt    <= 4'h0;
      ackPhase  <= 1'b0;
      sdaDrive  <= 1'b0;
      wrEn      <= 1'b0;
    end else begin
      wrEn <= 1'b0;
      if (startSeen) begin
        state    <= S_ADDR;
        bitCnt   <= 4'h0;
        ackPhase <= 1'b0;
        sdaDrive <= 1'b0;
      end else if (stopSeen) begin
        state    <= S_IDLE;
        ackPhase <= 1'b0;
        sdaDrive <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            sdaDrive <= 1'b0;
          end
          S_ADDR, S_REG, S_DATA: begin
            if (sclRise && !ackPhase && bitCnt != `LDSC_BYTE_BITS) begin
              shiftIn <= {shiftIn[6:0], sdaIn};
              bitCnt  <= bitCnt + 4'h1;
            end else if (sclFall && ackPhase) begin
              // ack clock over: release and move on
              ackPhase <= 1'b0;
              sdaDrive <= 1'b0;
              bitCnt   <= 4'h0;
              if (state == S_ADDR && shiftIn[0]) begin
                state    <= S_READ;
                readBuf  <= readData;
                sdaDrive <= ~readData[7];
              end else if (state == S_ADDR) begin
                state <= S_REG;
              end else begin
                state <= S_DATA;
              end
            end else if (sclFall && bitCnt == `LDSC_BYTE_BITS) begin
              if (state == S_ADDR && shiftIn[7:1] != SLAVE_ADDR[6:0]) begin
                state <= S_IDLE;
              end else begin
                ackPhase <= 1'b1;
                sdaDrive <= 1'b1;
                if (state == S_REG) begin
                  regAddr <= shiftIn;
                end
                if (state == S_DATA) begin
                  wrEn   <= 1'b1;
                  wrData <= shiftIn;
                end
              end
            end
          end
          S_READ: begin
            if (sclRise && bitCnt == `LDSC_BYTE_BITS) begin
              masterAck <= ~sdaIn;
            end else if (sclFall) begin
              if (bitCnt == `LDSC_BYTE_BITS) begin
                if (masterAck) begin
                  readBuf  <= readData;
                  sdaDrive <= ~readData[7];
                  bitCnt   <= 4'h0;
                end else begin
                  state <= S_IDLE;
                end
              end else if (bitCnt == 4'h7) begin
                sdaDrive <= 1'b0;
                bitCnt   <= `LDSC_BYTE_BITS;
              end else begin
                readBuf  <= {readBuf[6:0], 1'b0};
                sdaDrive <= ~readBuf[6];
                bitCnt   <= bitCnt + 4'h1;
              end
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // register bank with hardware loads of sensed pin levels
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      generalCtl     <= `LDSC_RST_GENERAL;
      pinFunc        <= `LDSC_RST_PIN_FUNC;
      auxCtl         <= `LDSC_RST_AUX_IO;
      patByte0       <= `LDSC_RST_PATTERN;
      patByte1       <= `LDSC_RST_PATTERN;
      patByte2       <= `LDSC_RST_PATTERN;
      patByte3       <= `LDSC_RST_PATTERN;
      primaryLevel   <= `LDSC_RST_LEVEL;
      secondaryLevel <= `LDSC_RST_LEVEL;
    end else if (hwShutdown) begin
      generalCtl     <= `LDSC_RST_GENERAL;
      pinFunc        <= `LDSC_RST_PIN_FUNC;
      auxCtl         <= `LDSC_RST_AUX_IO;
      patByte0       <= `LDSC_RST_PATTERN;
      patByte1       <= `LDSC_RST_PATTERN;
      patByte2       <= `LDSC_RST_PATTERN;
      patByte3       <= `LDSC_RST_PATTERN;
      primaryLevel   <= `LDSC_RST_LEVEL;
      secondaryLevel <= `LDSC_RST_LEVEL;
    end else if (wrEn) begin
      case (regAddr)
        `LDSC_ADDR_GENERAL:   generalCtl <= wrData | `LDSC_GC_FIXED_ONES;
        `LDSC_ADDR_PIN_FUNC:  pinFunc <= wrData;
        `LDSC_ADDR_AUX_IO:    auxCtl <= wrData | `LDSC_AUX_FIXED_ONES;
        `LDSC_ADDR_PATTERN0:  patByte0 <= wrData;
        `LDSC_ADDR_PATTERN1:  patByte1 <= wrData;
        `LDSC_ADDR_PATTERN2:  patByte2 <= wrData;
        `LDSC_ADDR_PATTERN3:  patByte3 <= wrData;
        `LDSC_ADDR_PRIMARY:   primaryLevel <= wrData;
        `LDSC_ADDR_SECONDARY: secondaryLevel <= wrData;
        default:              generalCtl <= generalCtl;
      endcase
    end else begin
      // input directions copy the sensed pin levels into the data bits
      if (ioMode && pinFunc[`LDSC_PF_DIR]) begin
        pinFunc[`LDSC_PF_DATA] <= mfpIn;
      end
      if (auxCtl[`LDSC_AUX_DIR]) begin
        auxCtl[`LDSC_AUX_DATA] <= auxIn;
      end
    end
  end

  // thermal shutdown with hysteresis
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      thermalOff <= 1'b0;
    end else if (dieTemp >= `LDSC_TEMP_TRIP) begin
      thermalOff <= 1'b1;
    end else if (dieTemp < `LDSC_TEMP_RELEASE) begin
      thermalOff <= 1'b0;
    end
  end

  // pin drivers: pull low only where the mode asks for it
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mfpOe <= 1'b0;
      auxOe <= 1'b0;
    end else begin
      mfpOe <= (patternMode & patPullLow) |
               (ioMode & ~pinFunc[`LDSC_PF_DIR] & ~pinFunc[`LDSC_PF_DATA]);
      // a zero written with output direction pulls low, a one releases
      auxOe <= ~auxCtl[`LDSC_AUX_DIR] & ~auxCtl[`LDSC_AUX_DATA];
    end
  end

  // sink enables, unison and analog-facing outputs
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      primarySinkOn    <= 1'b0;
      secondarySinkOn  <= 1'b0;
      switchOn         <= 1'b0;
      primaryCurrent   <= 7'h00;
      secondaryCurrent <= 7'h00;
      rampSelect       <= 2'h0;
      oledMode         <= 1'b0;
    end else begin
      primarySinkOn   <= deviceOn & generalCtl[`LDSC_GC_PRIMARY_EN];
      secondarySinkOn <= deviceOn & generalCtl[`LDSC_GC_SECONDARY_EN] &
                         ~generalCtl[`LDSC_GC_OLED];
      switchOn        <= deviceOn & (generalCtl[`LDSC_GC_PRIMARY_EN] |
                         generalCtl[`LDSC_GC_SECONDARY_EN] | generalCtl[`LDSC_GC_OLED]);
      primaryCurrent  <= primaryLevel[`LDSC_LEVEL_BITS-1:0];
      secondaryCurrent <= generalCtl[`LDSC_GC_UNISON] ?
                          primaryLevel[`LDSC_LEVEL_BITS-1:0] :
                          secondaryLevel[`LDSC_LEVEL_BITS-1:0];
      rampSelect      <= generalCtl[`LDSC_GC_RAMP_HI:`LDSC_GC_RAMP_LO];
      oledMode        <= generalCtl[`LDSC_GC_OLED];
    end
  end

endmodule // ldsc_top
`default_nettype wire

//--- core/ldsc_regs.vh
// register map, field positions, reset values and timing figures of the
// serial-controlled led driver register bank; definitions only
`ifndef LDSC_REGS_VH
`define LDSC_REGS_VH

// register offsets on the two-wire port
`define LDSC_ADDR_GENERAL     8'h10
`define LDSC_ADDR_PIN_FUNC    8'h80
`define LDSC_ADDR_AUX_IO      8'h81
`define LDSC_ADDR_PATTERN0    8'h90
`define LDSC_ADDR_PATTERN1    8'h91
`define LDSC_ADDR_PATTERN2    8'h92
`define LDSC_ADDR_PATTERN3    8'h93
`define LDSC_ADDR_PRIMARY     8'hA0
`define LDSC_ADDR_SECONDARY   8'hB0

// power-on values
`define LDSC_RST_GENERAL      8'hC0
`define LDSC_RST_LEVEL        8'hE0
`define LDSC_RST_PIN_FUNC     8'hF8
`define LDSC_RST_AUX_IO       8'hFC
`define LDSC_RST_PATTERN      8'h00

// general control fields
`define LDSC_GC_PRIMARY_EN    0
`define LDSC_GC_SECONDARY_EN  1
`define LDSC_GC_UNISON        2
`define LDSC_GC_RAMP_LO       3
`define LDSC_GC_RAMP_HI       4
`define LDSC_GC_OLED          5
`define LDSC_GC_FIXED_ONES    8'hC0

// pin function control fields
`define LDSC_PF_HARDWARE_ENABLE_MODE_OFF      0
`define LDSC_PF_DIR           1
`define LDSC_PF_DATA          2
`define LDSC_PF_DUTY_LO       3
`define LDSC_PF_DUTY_HI       5
`define LDSC_PF_FREQ_LO       6
`define LDSC_PF_FREQ_HI       7
`define LDSC_DUTY_IO          3'h0
`define LDSC_DUTY_LATCH       3'h7

// auxiliary io fields
`define LDSC_AUX_DIR          0
`define LDSC_AUX_DATA         1
`define LDSC_AUX_FIXED_ONES   8'hFC

// brightness level field width
`define LDSC_LEVEL_BITS       7

// thermal thresholds in degrees celsius
`define LDSC_TEMP_TRIP        8'd140
`define LDSC_TEMP_RELEASE     8'd120

// serial port: byte length and the device address (arbitrary value)
`define LDSC_BYTE_BITS        4'd8
`define LDSC_SLAVE_ADDR       7'h2A

// pattern timing: last sub-slot index of a pattern bit (eight sub-slots per bit) and base slot time
`define LDSC_SLOTS_PER_BIT    3'd7
`define LDSC_CLK_PERIOD_NS    40
`define LDSC_SLOT_TIME_NS     1000
`define LDSC_SLOT_CYCLES      ((`LDSC_SLOT_TIME_NS + `LDSC_CLK_PERIOD_NS - 1) / `LDSC_CLK_PERIOD_NS)

`endif

//--- core/ldsc_pattern.v
// pattern generator: 32-bit repeating pattern with frequency and duty choice
// assumes ref_clk at 25 MHz and that the caller decides when the pin is in
// pattern mode; clear is a synchronous shutdown from the hardware enable
`timescale 1ns/1ps
`default_nettype none
`include "ldsc_regs.vh"

module ldsc_pattern #(
  parameter PAT_BITS   = 32,
  parameter SLOT_BASE  = `LDSC_SLOT_CYCLES
) (
  input  wire                ref_clk,
  input  wire                rst_b,
  input  wire                clear,
  input  wire                latch,
  input  wire [PAT_BITS-1:0] patternIn,
  input  wire [1:0]          freqSel,
  input  wire [2:0]          dutySel,
  input  wire                enable,
  output reg                 pullLow
);

  // slot length grows by four for each frequency step
  function [23:0] slotLen;
    input [1:0] sel;
    begin
      slotLen = SLOT_BASE[23:0] << {sel, 1'b0};
    end
  endfunction

  reg  [PAT_BITS-1:0] shiftPat;
  reg  [23:0]         slotCnt;
  reg  [2:0]          slotIdx;
  wire                slotEnd;

  assign slotEnd = (slotCnt >= slotLen(freqSel) - 24'h000001);

  // timing and rotation of the pattern, loaded by the latch code
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      shiftPat <= {PAT_BITS{1'b0}};
      slotCnt  <= 24'h000000;
      slotIdx  <= 3'h0;
      pullLow  <= 1'b0;
    end else if (clear) begin
      shiftPat <= {PAT_BITS{1'b0}};
      slotCnt  <= 24'h000000;
      slotIdx  <= 3'h0;
      pullLow  <= 1'b0;
    end else if (latch) begin
      shiftPat <= patternIn;
      slotCnt  <= 24'h000000;
      slotIdx  <= 3'h0;
      pullLow  <= 1'b0;
    end else begin
      if (slotEnd) begin
        slotCnt <= 24'h000000;
        slotIdx <= slotIdx + 3'h1;
        if (slotIdx == `LDSC_SLOTS_PER_BIT) begin
          shiftPat <= {shiftPat[PAT_BITS-2:0], shiftPat[PAT_BITS-1]};
        end
      end else begin
        slotCnt <= slotCnt + 24'h000001;
      end
      // a one pulls low for dutySel eighths of the bit time
      pullLow <= enable & shiftPat[PAT_BITS-1] & (slotIdx < dutySel);
    end
  end

endmodule // ldsc_pattern
`default_nettype wire

//--- test/ldsc_host.sv
// two-wire bus master model standing in for the host processor
// assumes a pull-up on the data line; sdaWire is the resolved wire level
`timescale 1ns/1ps
`default_nettype none
`include "ldsc_regs.vh"

module ldsc_host #(
  parameter int         Q    = 4,
  parameter logic [6:0] ADDR = `LDSC_SLAVE_ADDR // arbitrary value
) (
  input  wire logic ref_clk,
  input  wire logic sdaWire,
  output var  logic scl,
  output var  logic sdaDrv
);
  int nakCount;

  // bus idles released, clock high
  initial begin
    scl      = 1'b1;
    sdaDrv   = 1'b1;
    nakCount = 0;
  end

  // all changes land just after a clock edge
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // data changes only while the clock is low
  task automatic clk_bit(input logic b, output logic got);
    hold(Q);
    sdaDrv = b;
    hold(Q);
    scl = 1'b1;
    hold(Q);
    got = sdaWire;
    hold(Q);
    scl = 1'b0;
  endtask

  // start or repeated start
  task automatic start_cond();
    hold(Q);
    sdaDrv = 1'b1;
    hold(Q);
    scl = 1'b1;
    hold(2*Q);
    sdaDrv = 1'b0;
    hold(2*Q);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    hold(Q);
    sdaDrv = 1'b0;
    hold(Q);
    scl = 1'b1;
    hold(2*Q);
    sdaDrv = 1'b1;
    hold(2*Q);
  endtask

  // eight bits msb first, then line released for the ninth clock
  task automatic put_byte(input logic [7:0] v);
    logic g;
    for (int i = 7; i >= 0; i--) clk_bit(v[i], g);
    clk_bit(1'b1, g);
    if (g !== 1'b0) nakCount++;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] v);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, g);
      v[i] = g;
    end
    clk_bit(last, g);
  endtask

  // address with write bit, register, data
  task automatic reg_write(input logic [7:0] r, input logic [7:0] d);
    start_cond();
    put_byte({ADDR, 1'b0});
    put_byte(r);
    put_byte(d);
    stop_cond();
  endtask

  task automatic reg_read(input logic [7:0] r, output logic [7:0] d);
    start_cond();
    put_byte({ADDR, 1'b0});
    put_byte(r);
    start_cond();
    put_byte({ADDR, 1'b1});
    get_byte(1'b1, d);
    stop_cond();
  endtask

  task automatic bad_addr();
    start_cond();
    put_byte({~ADDR, 1'b0});
    stop_cond();
  endtask
endmodule // ldsc_host

`default_nettype wire

//--- test/ldsc_props.sv
// timing checks on the led driver control block ports
// assumes bus clock phases of at least four ref_clk cycles, SLOT_BASE >= 2
`timescale 1ns/1ps
`default_nettype none

module ldsc_props (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       scl,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       mfpOut,
  input wire logic       mfpOe,
  input wire logic       auxOut,
  input wire logic       auxOe,
  input wire logic [7:0] dieTemp,
  input wire logic       primarySinkOn,
  input wire logic       secondarySinkOn,
  input wire logic       switchOn,
  input wire logic       oledMode
);
  logic       sclQ;
  logic       sdaQ;
  logic       inAddr;
  logic [3:0] riseCnt;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // counts clock rises since the last start condition
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclQ    <= 1'b1;
      sdaQ    <= 1'b1;
      inAddr  <= 1'b0;
      riseCnt <= 4'h0;
    end else begin
      sclQ <= scl;
      sdaQ <= sdaIn;
      if (scl && sclQ && sdaQ && !sdaIn) begin
        inAddr  <= 1'b1;
        riseCnt <= 4'h0;
      end else begin
        if (scl && !sclQ && riseCnt != 4'hF) riseCnt <= riseCnt + 4'h1;
        if (sdaOe) inAddr <= 1'b0;
      end
    end
  end

  open_drain_a: assert property (!sdaOut && !mfpOut && !auxOut)
    else $error("open-drain data output not low");
  sda_edge_a: assert property ($changed(sdaOe) |-> !scl)
    else $error("data line moved while bus clock high");
  ack_hold_a: assert property ($rose(sdaOe) |-> sdaOe [*8])
    else $error("data line pull shorter than one bit");
  ack_ninth_a: assert property (inAddr && $rose(sdaOe) |-> riseCnt == 4'd8)
    else $error("first pull after start not on ninth clock");
  hot_off_a: assert property ((dieTemp >= 8'd140) [*3] |=>
      !switchOn && !primarySinkOn && !secondarySinkOn)
    else $error("outputs active while over temperature");
  cool_on_a: assert property ($rose(primarySinkOn) |-> $past(dieTemp) < 8'd120)
    else $error("sink enabled at high temperature");
  // reset and enable shutdown reload a driving aux value with the switch off
  aux_drive_a: assert property ($rose(auxOe) && switchOn |-> !scl)
    else $error("aux pin driven outside a register store");
  switch_need_a: assert property ($rose(switchOn) |->
      primarySinkOn || secondarySinkOn || oledMode)
    else $error("switch active with nothing enabled");
  // stores land with the bus clock low and may cut a slot short
  mfp_slot_a: assert property ($rose(mfpOe) && scl |-> mfpOe [*2])
    else $error("pin pull shorter than one slot");

  cover property (inAddr && $rose(sdaOe));
  cover property ($fell(primarySinkOn) && dieTemp >= 8'd140);
  cover property ($rose(mfpOe) ##[1:40] $fell(mfpOe));
  cover property ($rose(auxOe));
endmodule // ldsc_props

bind ldsc_top ldsc_props u_props (
  .ref_clk(ref_clk), .rst_b(rst_b), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .mfpOut(mfpOut), .mfpOe(mfpOe), .auxOut(auxOut), .auxOe(auxOe),
  .dieTemp(dieTemp), .primarySinkOn(primarySinkOn), .secondarySinkOn(secondarySinkOn),
  .switchOn(switchOn), .oledMode(oledMode)
);

`default_nettype wire

//--- test/test_led_driver_serial_control.sv
// self-checking bench for the led driver control block
// assumes pull-ups on all open-drain pins; the bench pulls pins low on demand
`timescale 1ns/1ps
`default_nettype none
`include "ldsc_regs.vh"

`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin numErrors++; \
  $display("BAD %s expected %h seen %h", what, exp, got); end end

module test_led_driver_serial_control;
  localparam int SB = 2;
  logic       ref_clk, rst_b, mfpLow, auxLow;
  logic [7:0] dieTemp, rd;
  wire        scl, hostSda, sdaOut, sdaOe, mfpOut, mfpOe, auxOut, auxOe;
  wire        priOn, secOn, swOn, oled;
  wire  [6:0] priCur, secCur;
  wire  [1:0] ramp;
  int         numErrors, checked, c;
  logic [7:0] addrTab [9] = '{`LDSC_ADDR_GENERAL, `LDSC_ADDR_PRIMARY, `LDSC_ADDR_SECONDARY,
    `LDSC_ADDR_PIN_FUNC, `LDSC_ADDR_AUX_IO, `LDSC_ADDR_PATTERN0, `LDSC_ADDR_PATTERN1,
    `LDSC_ADDR_PATTERN2, `LDSC_ADDR_PATTERN3};
  logic [7:0] rstTab [9] = '{8'hC0, 8'hE0, 8'hE0, 8'hF8, 8'hFC, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] patTab [4] = '{8'hA5, 8'h00, 8'h00, 8'h0F};

  // wired pins with pull-ups
  wire sdaWire = ~(sdaOe | ~hostSda);
  wire mfpWire = ~(mfpOe | mfpLow);
  wire auxWire = ~(auxOe | auxLow);

  always #20 ref_clk = ~ref_clk;

  ldsc_top #(.SLOT_BASE(SB)) u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .mfpIn(mfpWire), .mfpOut(mfpOut), .mfpOe(mfpOe), .auxIn(auxWire),
    .auxOut(auxOut), .auxOe(auxOe), .dieTemp(dieTemp), .primarySinkOn(priOn),
    .secondarySinkOn(secOn), .switchOn(swOn), .primaryCurrent(priCur),
    .secondaryCurrent(secCur), .rampSelect(ramp), .oledMode(oled)
  );

  ldsc_host u_host (.ref_clk(ref_clk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(hostSda));

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
    u_host.reg_read(a, rd);
    `CHK("register", e, rd)
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.reg_write(a, d);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // counts cycles with the multi-function pin pulled low
  task automatic count_low(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      settle(1);
      if (mfpOe === 1'b1) cnt++;
    end
  endtask

  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog beyond the expected run of about 73k cycles
  initial begin
    #(95000 * 40);
    numErrors++;
    $display("BAD watchdog expected finish seen timeout");
    wrapUp();
  end

  initial begin
    ref_clk = 1'b0; rst_b = 1'b0; mfpLow = 1'b0; auxLow = 1'b0; dieTemp = 8'd25;
    numErrors = 0; checked = 0;
    settle(20);
    rst_b = 1'b1;
    settle(2);
    for (int i = 0; i < 9; i++) expect_reg(addrTab[i], rstTab[i]);
    expect_reg(8'h55, 8'h00);
    `CHK("nak count", 0, u_host.nakCount)
    u_host.bad_addr();
    `CHK("nak count", 1, u_host.nakCount)
    // levels, enables, unison and the analog-facing fields
    wr(`LDSC_ADDR_PRIMARY, 8'h85);
    wr(`LDSC_ADDR_SECONDARY, 8'h11);
    wr(`LDSC_ADDR_GENERAL, 8'h03);
    `CHK("pri cur", 7'h05, priCur)
    `CHK("sec cur", 7'h11, secCur)
    `CHK("sinks on", 2'b11, {priOn, secOn})
    expect_reg(`LDSC_ADDR_GENERAL, 8'hC3);
    wr(`LDSC_ADDR_GENERAL, 8'h06);
    `CHK("unison cur", 7'h05, secCur)
    `CHK("sinks", 2'b01, {priOn, secOn})
    wr(`LDSC_ADDR_GENERAL, 8'h38);
    `CHK("ramp oled", 3'b111, {ramp, oled})
    `CHK("oled sinks", 3'b001, {priOn, secOn, swOn})
    // thermal trip and hysteresis
    wr(`LDSC_ADDR_GENERAL, 8'h03);
    dieTemp = 8'd140;
    settle(6);
    `CHK("hot off", 2'b00, {priOn, swOn})
    dieTemp = 8'd130;
    settle(6);
    `CHK("warm off", 1'b0, priOn)
    dieTemp = 8'd119;
    settle(6);
    `CHK("cool on", 1'b1, priOn)
    // auxiliary pin: output set up first, then level
    wr(`LDSC_ADDR_AUX_IO, 8'h02);
    `CHK("aux high", 1'b0, auxOe)
    wr(`LDSC_ADDR_AUX_IO, 8'h00);
    `CHK("aux low", 1'b1, auxOe)
    wr(`LDSC_ADDR_AUX_IO, 8'h01);
    auxLow = 1'b1;
    expect_reg(`LDSC_ADDR_AUX_IO, 8'hFD);
    auxLow = 1'b0;
    expect_reg(`LDSC_ADDR_AUX_IO, 8'hFF);
    // multi-function pin as general io
    wr(`LDSC_ADDR_PIN_FUNC, 8'h01);
    `CHK("mfp low", 1'b1, mfpOe)
    wr(`LDSC_ADDR_PIN_FUNC, 8'h05);
    `CHK("mfp open", 1'b0, mfpOe)
    wr(`LDSC_ADDR_PIN_FUNC, 8'h03);
    mfpLow = 1'b1;
    expect_reg(`LDSC_ADDR_PIN_FUNC, 8'h03);
    mfpLow = 1'b0;
    expect_reg(`LDSC_ADDR_PIN_FUNC, 8'h07);
    // pattern: latch eight ones, then change a byte without latching
    for (int i = 0; i < 4; i++) wr(8'h90 + 8'(i), patTab[i]);
    wr(`LDSC_ADDR_PIN_FUNC, 8'h39);
    `CHK("latch open", 1'b0, mfpOe)
    wr(`LDSC_ADDR_PATTERN0, 8'hFF);
    for (int d = 1; d <= 6; d++) begin
      wr(`LDSC_ADDR_PIN_FUNC, {2'b00, 3'(d), 3'b001});
      settle(8 * SB);
      count_low(256 * SB, c);
      `CHK("duty low", 8 * d * SB, c)
    end
    for (int f = 1; f <= 3; f++) begin
      wr(`LDSC_ADDR_PIN_FUNC, {2'(f), 3'd4, 3'b001});
      settle(8 * SB * (4 ** f));
      count_low(256 * SB * (4 ** f), c);
      `CHK("freq low", 32 * SB * (4 ** f), c)
    end
    // back to hardware enable, still running, then pull the pin low
    wr(`LDSC_ADDR_PIN_FUNC, 8'h00);
    `CHK("enable on", 1'b1, priOn)
    mfpLow = 1'b1;
    settle(4);
    `CHK("shutdown", 3'b000, {priOn, secOn, swOn})
    mfpLow = 1'b0;
    settle(4);
    expect_reg(`LDSC_ADDR_GENERAL, 8'hC0);
    expect_reg(`LDSC_ADDR_PIN_FUNC, 8'hF8);
    expect_reg(`LDSC_ADDR_PATTERN3, 8'h00);
    wrapUp();
  end
endmodule // test_led_driver_serial_control

`default_nettype wire
